// *** hdl/flash_program_erase_protect.sv ***
// Flash program, erase and protection controller with AXI4-Lite registers.
// Assumes a flash array that clears bits on program and sets bits on erase.
// Contract
// R1 - Erase acts on one aligned 1-KB page, leaving all its bits one.
// R2 - Program acts on one aligned 32-bit word, only clearing bits.
// R3 - Each 2-KB region has one read-enable and one program-enable bit.
// R4 - Software loads reload value as clock MHz minus one before modifying.
// R5 - Reload register resets to a value safe at maximum clock.
// R6 - Program-enable one allows program and erase; zero forbids change.
// R7 - Read-enable one allows data reads; zero allows only fetches.
// R8 - Program on, read off: write, erase, fetch allowed; data reads denied.
// R9 - Program off, read on: reads and fetches allowed; changes refused.
// R10 - Execute-only region serves fetches only, denies data and debug reads.
// R11 - Program or erase of protected region blocked; masked interrupt raised.
// R12 - Data read of read-protected region returns zero; interrupt optional.
// R13 - All protection bits default to one.
// R14 - Protection writes act at once, become permanent only on commit.
// R15 - Uncommitted cleared bits return to stored value on power-on reset.
// R16 - Keyed write command programs a word; write bit clears when done.
// R17 - Keyed erase command erases a page; erase bit clears when done.
// R18 - Keyed mass-erase command erases all; its bit clears when done.
// R19 - Software gives word-aligned program and page-aligned erase addresses.
// R20 - Keyed commit stores selected protection word; bit clears when done.
// R21 - Control writes without the key start nothing.
module flash_program_erase_protect #(
	parameter int ADDR_W = 17
) (
	// Clock and resets
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              por_n,
	// AXI4-Lite slave
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [11:0]       s_axi_awaddr,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [11:0]       s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	// Flash read path
	input  wire logic              rd_req,
	input  wire logic [ADDR_W-1:0] rd_addr,
	input  wire logic              rd_fetch,
	output logic                   rd_ack,
	output logic [31:0]            rd_data,
	// Flash array
	output logic [ADDR_W-1:0]      array_raddr,
	input  wire logic [31:0]       array_rdata,
	output logic                   array_program,
	output logic                   array_erase,
	output logic                   array_mass_erase,
	output logic [ADDR_W-1:0]      array_addr,
	output logic [31:0]            array_wdata,
	// Interrupt
	output logic                   irq
);
	logic                   aw_held_reg;
	logic                   w_held_reg;
	logic [11:0]            waddr_reg;
	logic [31:0]            wdata_reg;
	logic [3:0]             wstrb_reg;
	logic                   wr_fire;
	logic [ADDR_W-1:0]      addr_reg;
	logic [31:0]            data_reg;
	logic [3:0]             ctrl_reg;
	logic [7:0]             usec_reg;
	logic [1:0]             raw_reg;
	logic [1:0]             mask_reg;
	logic [63:0]            re_live_reg;
	logic [63:0]            pe_live_reg;
	logic [63:0]            re_nv_reg;
	logic [63:0]            pe_nv_reg;
	flash_pkg::seq_state_t  state_reg;
	logic [7:0]             tick_cnt_reg;
	logic [15:0]            us_left_reg;
	logic                   tick;
	logic                   op_done;
	logic                   key_ok;
	logic                   cmd_wr;
	logic                   denied;
	logic                   rd_denied;
	logic [31:0]            rdata_next;
	logic                   rd_hit;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Write address and data are taken independently, then answered together
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			waddr_reg   <= 12'h000;
			wdata_reg   <= 32'h00000000;
			wstrb_reg   <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				waddr_reg   <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= flash_pkg::RESP_OK;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			case (waddr_reg)
				flash_pkg::OFS_ADDR, flash_pkg::OFS_DATA, flash_pkg::OFS_CTRL,
				flash_pkg::OFS_RAW, flash_pkg::OFS_MASK, flash_pkg::OFS_CLR,
				flash_pkg::OFS_USEC, flash_pkg::OFS_RE0, flash_pkg::OFS_RE1,
				flash_pkg::OFS_PE0, flash_pkg::OFS_PE1: s_axi_bresp <= flash_pkg::RESP_OK;
				default: s_axi_bresp <= flash_pkg::RESP_ERR;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Plain data registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_reg <= '0;
			data_reg <= 32'h00000000;
			usec_reg <= flash_pkg::USEC_RST; // R5
			mask_reg <= 2'h0;
		end else if (wr_fire) begin
			if (waddr_reg == flash_pkg::OFS_ADDR) begin
				addr_reg <= ADDR_W'(merge(32'(addr_reg), wdata_reg, wstrb_reg));
			end
			if (waddr_reg == flash_pkg::OFS_DATA) begin
				data_reg <= merge(data_reg, wdata_reg, wstrb_reg);
			end
			if (waddr_reg == flash_pkg::OFS_USEC && wstrb_reg[0]) begin
				usec_reg <= wdata_reg[7:0]; // R4
			end
			if (waddr_reg == flash_pkg::OFS_MASK && wstrb_reg[0]) begin
				mask_reg <= wdata_reg[1:0];
			end
		end
	end

	// Commands need the key and a whole upper half; busy sequencer ignores them
	assign key_ok = wdata_reg[31:16] == flash_pkg::WRITE_KEY && wstrb_reg[3:2] == 2'h3; // R21
	assign cmd_wr = wr_fire && waddr_reg == flash_pkg::OFS_CTRL && wstrb_reg[0] && key_ok
		&& state_reg == flash_pkg::ST_IDLE && wdata_reg[3:0] != 4'h0;
	always_comb begin
		denied = 1'b0;
		if (wdata_reg[flash_pkg::BIT_WRITE] || wdata_reg[flash_pkg::BIT_ERASE]) begin
			denied = !pe_live_reg[addr_reg[16:11]]; // R3 R6 R9
		end else if (wdata_reg[flash_pkg::BIT_MASS]) begin
			denied = !(&pe_live_reg); // R6
		end
	end

	// Microsecond tick from the reload value, free running
	assign tick    = tick_cnt_reg == 8'h00;
	assign op_done = state_reg == flash_pkg::ST_RUN && tick && us_left_reg == 16'h0000;
	always_ff @(posedge aclk) begin
		if (!aresetn || tick) begin
			tick_cnt_reg <= usec_reg;
		end else begin
			tick_cnt_reg <= tick_cnt_reg - 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg   <= flash_pkg::ST_IDLE;
			ctrl_reg    <= 4'h0;
			us_left_reg <= 16'h0000;
			array_addr  <= '0;
			array_wdata <= 32'hFFFFFFFF;
		end else begin
			case (state_reg)
				flash_pkg::ST_IDLE: begin
					if (cmd_wr && !denied) begin // R11 R21
						state_reg <= flash_pkg::ST_RUN;
						array_wdata <= data_reg; // R2
						if (wdata_reg[flash_pkg::BIT_WRITE]) begin
							ctrl_reg    <= 4'h1; // R16
							us_left_reg <= flash_pkg::PROG_US;
							array_addr  <= {addr_reg[ADDR_W-1:2], 2'h0}; // R2 R19
						end else if (wdata_reg[flash_pkg::BIT_ERASE]) begin
							ctrl_reg    <= 4'h2; // R17
							us_left_reg <= flash_pkg::ERASE_US;
							array_addr  <= {addr_reg[ADDR_W-1:10], 10'h000}; // R1 R19
						end else if (wdata_reg[flash_pkg::BIT_MASS]) begin
							ctrl_reg    <= 4'h4; // R18
							us_left_reg <= flash_pkg::MASS_US;
						end else begin
							ctrl_reg    <= 4'h8; // R20
							us_left_reg <= flash_pkg::COMMIT_US;
						end
					end
				end
				flash_pkg::ST_RUN: begin
					if (op_done) begin
						state_reg <= flash_pkg::ST_IDLE;
						ctrl_reg  <= 4'h0; // R16 R17 R18 R20
					end else if (tick) begin
						us_left_reg <= us_left_reg - 16'h0001;
					end
				end
				default: state_reg <= flash_pkg::ST_IDLE;
			endcase
		end
	end

	assign array_program    = state_reg == flash_pkg::ST_RUN && ctrl_reg[flash_pkg::BIT_WRITE];
	assign array_erase      = state_reg == flash_pkg::ST_RUN && ctrl_reg[flash_pkg::BIT_ERASE];
	assign array_mass_erase = state_reg == flash_pkg::ST_RUN && ctrl_reg[flash_pkg::BIT_MASS];

	// Stored image survives system reset; only power-on reset restores it
	always_ff @(posedge aclk) begin
		if (!por_n) begin
			re_nv_reg <= flash_pkg::PROT_RST; // R13
			pe_nv_reg <= flash_pkg::PROT_RST; // R13
		end else if (op_done && ctrl_reg[flash_pkg::BIT_COMMIT]) begin
			// Committed bits can only fall
			case (addr_reg)
				flash_pkg::SEL_RE0: re_nv_reg[31:0]  <= re_nv_reg[31:0] & re_live_reg[31:0];
				flash_pkg::SEL_PE0: pe_nv_reg[31:0]  <= pe_nv_reg[31:0] & pe_live_reg[31:0];
				flash_pkg::SEL_RE1: re_nv_reg[63:32] <= re_nv_reg[63:32] & re_live_reg[63:32];
				flash_pkg::SEL_PE1: pe_nv_reg[63:32] <= pe_nv_reg[63:32] & pe_live_reg[63:32];
				default: re_nv_reg <= re_nv_reg;
			endcase // R14 R20
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			re_live_reg <= re_nv_reg; // R15
			pe_live_reg <= pe_nv_reg; // R15
		end else if (wr_fire) begin
			for (int w = 0; w < 2; w++) begin
				if (waddr_reg == flash_pkg::OFS_RE0 + 12'(4 * w)) begin
					re_live_reg[32*w +: 32] <= merge(re_live_reg[32*w +: 32], wdata_reg, wstrb_reg); // R14
				end
				if (waddr_reg == flash_pkg::OFS_PE0 + 12'(4 * w)) begin
					pe_live_reg[32*w +: 32] <= merge(pe_live_reg[32*w +: 32], wdata_reg, wstrb_reg); // R14
				end
			end
		end
	end

	// Read path: fetches always pass, data reads need read enable
	assign array_raddr = rd_addr;
	assign rd_denied   = rd_req && !rd_fetch && !re_live_reg[rd_addr[16:11]]; // R7 R8 R10
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_ack  <= 1'b0;
			rd_data <= 32'h00000000;
		end else begin
			rd_ack  <= rd_req;
			rd_data <= rd_denied ? 32'h00000000 : array_rdata; // R12
		end
	end

	// Violation flags: a new event beats a same-cycle clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			raw_reg <= 2'h0;
		end else begin
			raw_reg[flash_pkg::BIT_PVIOL] <= (cmd_wr && denied) // R11
				|| (raw_reg[flash_pkg::BIT_PVIOL] && !(wr_fire && waddr_reg == flash_pkg::OFS_CLR
				&& wstrb_reg[0] && wdata_reg[flash_pkg::BIT_PVIOL]));
			raw_reg[flash_pkg::BIT_RVIOL] <= rd_denied // R12
				|| (raw_reg[flash_pkg::BIT_RVIOL] && !(wr_fire && waddr_reg == flash_pkg::OFS_CLR
				&& wstrb_reg[0] && wdata_reg[flash_pkg::BIT_RVIOL]));
		end
	end
	assign irq = |(raw_reg & mask_reg); // R11 R12

	// Register read, one cycle after the address is taken
	assign s_axi_arready = !s_axi_rvalid;
	always_comb begin
		rd_hit     = 1'b1;
		rdata_next = 32'h00000000;
		case (s_axi_araddr)
			flash_pkg::OFS_ADDR: rdata_next = 32'(addr_reg);
			flash_pkg::OFS_DATA: rdata_next = data_reg;
			flash_pkg::OFS_CTRL: rdata_next = {28'h0000000, ctrl_reg};
			flash_pkg::OFS_RAW:  rdata_next = {30'h00000000, raw_reg};
			flash_pkg::OFS_MASK: rdata_next = {30'h00000000, mask_reg};
			flash_pkg::OFS_CLR:  rdata_next = {30'h00000000, raw_reg & mask_reg};
			flash_pkg::OFS_USEC: rdata_next = {24'h000000, usec_reg};
			flash_pkg::OFS_RE0:  rdata_next = re_live_reg[31:0];
			flash_pkg::OFS_RE1:  rdata_next = re_live_reg[63:32];
			flash_pkg::OFS_PE0:  rdata_next = pe_live_reg[31:0];
			flash_pkg::OFS_PE1:  rdata_next = pe_live_reg[63:32];
			default:             rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= flash_pkg::RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rdata_next;
			s_axi_rresp  <= rd_hit ? flash_pkg::RESP_OK : flash_pkg::RESP_ERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	a_key_gate: assert property (@(posedge aclk) disable iff (!aresetn) // R21
		wr_fire && waddr_reg == flash_pkg::OFS_CTRL && !key_ok && state_reg == flash_pkg::ST_IDLE
		|=> state_reg == flash_pkg::ST_IDLE) else $error("unkeyed command started");
	a_prog_block: assert property (@(posedge aclk) disable iff (!aresetn) // R11
		cmd_wr && denied |=> raw_reg[flash_pkg::BIT_PVIOL] && state_reg == flash_pkg::ST_IDLE)
		else $error("protected change not blocked");
	a_read_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R12
		rd_req && !rd_fetch && !re_live_reg[rd_addr[16:11]] |=> rd_ack && rd_data == 32'h0)
		else $error("protected read leaked data");
	a_fetch_pass: assert property (@(posedge aclk) disable iff (!aresetn) // R10
		rd_req && rd_fetch |=> rd_data == $past(array_rdata)) else $error("fetch blocked");
	a_read_open: assert property (@(posedge aclk) disable iff (!aresetn) // R7
		rd_req && re_live_reg[rd_addr[16:11]] |=> rd_data == $past(array_rdata))
		else $error("open read blocked");
	a_usec_reset: assert property (@(posedge aclk) // R5
		!aresetn |=> usec_reg == flash_pkg::USEC_RST) else $error("bad reload reset");
	a_prot_default: assert property (@(posedge aclk) // R13
		!por_n |=> &re_nv_reg && &pe_nv_reg) else $error("bad protection default");
	a_done_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R16
		op_done |=> ctrl_reg == 4'h0 && !array_program && !array_erase)
		else $error("command bit not cleared");
	a_word_align: assert property (@(posedge aclk) disable iff (!aresetn) // R2
		array_program |-> array_addr[1:0] == 2'h0) else $error("unaligned program");
	a_page_align: assert property (@(posedge aclk) disable iff (!aresetn) // R1
		array_erase |-> array_addr[9:0] == 10'h000) else $error("unaligned erase");
	a_irq_raise: assert property (@(posedge aclk) disable iff (!aresetn) // R11
		cmd_wr && denied && mask_reg[flash_pkg::BIT_PVIOL] |=> irq) else $error("no interrupt");
	c_program: cover property (@(posedge aclk) disable iff (!aresetn)
		op_done && ctrl_reg[flash_pkg::BIT_WRITE]);
	c_erase: cover property (@(posedge aclk) disable iff (!aresetn)
		op_done && ctrl_reg[flash_pkg::BIT_ERASE]);
	c_read_block: cover property (@(posedge aclk) disable iff (!aresetn) rd_denied);
endmodule

// *** pkg/flash_pkg.sv ***
// Constants, offsets and types of the flash sequencer and protection block.
// Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
package flash_pkg;
	// Register byte offsets
	localparam logic [11:0] OFS_ADDR  = 12'h000;
	localparam logic [11:0] OFS_DATA  = 12'h004;
	localparam logic [11:0] OFS_CTRL  = 12'h008;
	localparam logic [11:0] OFS_RAW   = 12'h00C;
	localparam logic [11:0] OFS_MASK  = 12'h010;
	localparam logic [11:0] OFS_CLR   = 12'h014;
	localparam logic [11:0] OFS_USEC  = 12'h140;
	localparam logic [11:0] OFS_RE0   = 12'h200;
	localparam logic [11:0] OFS_RE1   = 12'h204;
	localparam logic [11:0] OFS_PE0   = 12'h400;
	localparam logic [11:0] OFS_PE1   = 12'h404;
	// Control word fields
	localparam logic [15:0] WRITE_KEY  = 16'hA442;
	localparam int          BIT_WRITE  = 0;
	localparam int          BIT_ERASE  = 1;
	localparam int          BIT_MASS   = 2;
	localparam int          BIT_COMMIT = 3;
	// Status and mask bit positions
	localparam int          BIT_PVIOL  = 0;
	localparam int          BIT_RVIOL  = 1;
	// Commit selectors held in the address register
	localparam logic [16:0] SEL_RE0    = 17'h00000;
	localparam logic [16:0] SEL_PE0    = 17'h00001;
	localparam logic [16:0] SEL_RE1    = 17'h00002;
	localparam logic [16:0] SEL_PE1    = 17'h00003;
	// Reset values
	localparam logic [7:0]  USEC_RST   = 8'h31;
	localparam logic [63:0] PROT_RST   = 64'hFFFFFFFFFFFFFFFF;
	// Operation lengths in microseconds
	localparam logic [15:0] PROG_US    = 16'h0014;
	localparam logic [15:0] ERASE_US   = 16'h0064;
	localparam logic [15:0] MASS_US    = 16'h00C8;
	localparam logic [15:0] COMMIT_US  = 16'h0014;
	// Bus answers
	localparam logic [1:0]  RESP_OK    = 2'h0;
	localparam logic [1:0]  RESP_ERR   = 2'h2;
	typedef enum logic [0:0] {ST_IDLE, ST_RUN} seq_state_t;
endpackage

// *** test/flash_array_model.sv ***
// Behavioural flash array: 128 KB of words, program clears, erase sets.
// Assumes the controller holds each strobe for the whole operation.
module flash_array_model (
	// Clock
	input  wire logic        aclk,
	// Controller side
	input  wire logic [16:0] array_raddr,
	output logic [31:0]      array_rdata,
	input  wire logic        array_program,
	input  wire logic        array_erase,
	input  wire logic        array_mass_erase,
	input  wire logic [16:0] array_addr,
	input  wire logic [31:0] array_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:32767];
	logic        prog_q;
	logic        erase_q;
	logic        mass_q;
	initial begin
		foreach (mem[i]) mem[i] = 32'hFFFF_FFFF;
		prog_q = 1'b0;
		erase_q = 1'b0;
		mass_q = 1'b0;
	end
	assign array_rdata = mem[array_raddr[16:2]];
	// Act on the leading edge only, so a long strobe is one operation
	always @(posedge aclk) begin
		prog_q <= array_program;
		erase_q <= array_erase;
		mass_q <= array_mass_erase;
		if (array_program && !prog_q) begin
			mem[array_addr[16:2]] <= mem[array_addr[16:2]] & array_wdata;
		end
		if (array_erase && !erase_q) begin
			for (int i = 0; i < 256; i++) mem[{array_addr[16:10], i[7:0]}] <= 32'hFFFF_FFFF;
		end
		if (array_mass_erase && !mass_q) begin
			foreach (mem[i]) mem[i] <= 32'hFFFF_FFFF;
		end
	end
endmodule

// *** test/flash_program_erase_protect_tb_top.sv ***
// Self-checking bench for the flash controller with a behavioural array.
// Assumes the package offsets and a reload of one to keep operations short.
module flash_program_erase_protect_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0;
	logic        aresetn;
	logic        por_n;
	logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
	logic [11:0] awa, ara;
	logic [31:0] wd, rdat, rd_data, a_rdata, a_wdata, exp_w, v, d1;
	logic [3:0]  ws;
	logic [1:0]  bresp, rresp, rs;
	logic        rd_req, rd_fetch, rd_ack, a_prog, a_erase, a_mass, irq;
	logic [16:0] rd_addr, a_raddr, a_addr, wa;
	logic [11:0] prot [4] = '{flash_pkg::OFS_RE0, flash_pkg::OFS_RE1,
		flash_pkg::OFS_PE0, flash_pkg::OFS_PE1};
	int          n_errors = 0;
	int          checks_done = 0;

	always #5 aclk = ~aclk;

	flash_program_erase_protect DUT (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat),
		.s_axi_rresp(rresp), .rd_req(rd_req), .rd_addr(rd_addr), .rd_fetch(rd_fetch),
		.rd_ack(rd_ack), .rd_data(rd_data), .array_raddr(a_raddr), .array_rdata(a_rdata),
		.array_program(a_prog), .array_erase(a_erase), .array_mass_erase(a_mass),
		.array_addr(a_addr), .array_wdata(a_wdata), .irq(irq));

	flash_array_model array_model (.aclk(aclk), .array_raddr(a_raddr), .array_rdata(a_rdata),
		.array_program(a_prog), .array_erase(a_erase), .array_mass_erase(a_mass),
		.array_addr(a_addr), .array_wdata(a_wdata));

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic hang();
		n_errors++;
		$display("unexpected wait: expected answer seen none");
		give_verdict();
	endtask

	// Array may only clear bits on program
	function automatic logic [31:0] programmed(input logic [31:0] old, input logic [31:0] d);
		return old & d;
	endfunction

	task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_flag(input string what, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %b seen %b", what, e, g);
		end
	endtask

	task automatic do_reset(input logic keep_image);
		@(posedge aclk);
		aresetn <= 1'b0;
		por_n <= keep_image;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		por_n <= 1'b1;
	endtask

	// Both channels offered together; each dropped at its own handshake edge
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int   i;
		logic ag, wg, bs;
		@(posedge aclk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		br <= 1'b1;
		for (i = 0; i < 50; i++) begin
			#1;
			ag = awv & awr;
			wg = wv & wr;
			bs = bv;
			r = bresp;
			@(posedge aclk);
			if (ag) awv <= 1'b0;
			if (wg) wv <= 1'b0;
			if (bs === 1'b1) begin
				br <= 1'b0;
				break;
			end
		end
		if (i == 50) hang();
	endtask

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int   i;
		logic ag, rs_v;
		@(posedge aclk);
		arv <= 1'b1;
		ara <= a;
		rr <= 1'b1;
		for (i = 0; i < 50; i++) begin
			#1;
			ag = arv & arr;
			rs_v = rv;
			d = rdat;
			r = rresp;
			@(posedge aclk);
			if (ag) arv <= 1'b0;
			if (rs_v === 1'b1) begin
				rr <= 1'b0;
				break;
			end
		end
		if (i == 50) hang();
	endtask

	task automatic flash_rd(input logic [16:0] a, input logic f, output logic [31:0] d);
		int i;
		@(posedge aclk);
		rd_req <= 1'b1;
		rd_addr <= a;
		rd_fetch <= f;
		@(posedge aclk);
		rd_req <= 1'b0;
		for (i = 0; i < 4; i++) begin
			#1;
			if (rd_ack === 1'b1) break;
			@(posedge aclk);
		end
		if (i == 4) hang();
		d = rd_data;
	endtask

	// Refused commands never show busy, so the first poll tells them apart
	task automatic run_cmd(input logic [15:0] op, input logic busy);
		int i;
		axi_wr(flash_pkg::OFS_CTRL, {flash_pkg::WRITE_KEY, op}, rs);
		for (i = 0; i < 300; i++) begin
			axi_rd(flash_pkg::OFS_CTRL, v, rs);
			if (i == 0) chk_word("control busy", busy ? {16'h0000, op} : 32'h0, v);
			if (v === 32'h0000_0000) break;
		end
		if (i == 300) hang();
	endtask

	initial begin
		aresetn = 1'b0;
		por_n = 1'b0;
		{awv, wv, br, arv, rr, rd_req, rd_fetch} = '0;
		{awa, ara, wd, rd_addr} = '0;
		ws = 4'hF;
		void'($urandom(12));
		do_reset(1'b0);
		axi_rd(flash_pkg::OFS_USEC, v, rs);
		chk_word("reload reset", {24'h0, flash_pkg::USEC_RST}, v);
		foreach (prot[k]) begin
			axi_rd(prot[k], v, rs);
			chk_word("protection reset", 32'hFFFF_FFFF, v);
		end
		axi_rd(12'h0F0, v, rs);
		chk_word("unmapped read", {30'h0, flash_pkg::RESP_ERR}, {30'h0, rs});
		axi_wr(12'h0F0, 32'h0000_0000, rs);
		chk_word("unmapped write", {30'h0, flash_pkg::RESP_ERR}, {30'h0, rs});
		axi_wr(flash_pkg::OFS_USEC, 32'h0000_0001, rs);
		chk_word("reload write", {30'h0, flash_pkg::RESP_OK}, {30'h0, rs});
		wa = {6'h00, 9'($urandom), 2'b00};
		exp_w = 32'hFFFF_FFFF;
		axi_wr(flash_pkg::OFS_ADDR, {15'h0, wa}, rs);
		for (int k = 0; k < 4; k++) begin
			d1 = $urandom;
			exp_w = programmed(exp_w, d1);
			axi_wr(flash_pkg::OFS_DATA, d1, rs);
			run_cmd(16'h0001, 1'b1);
			flash_rd(wa, 1'b0, v);
			chk_word("programmed word", exp_w, v);
		end
		axi_wr(flash_pkg::OFS_ADDR, {15'h0, wa[16:10], 10'h000}, rs);
		run_cmd(16'h0002, 1'b1);
		flash_rd(wa, 1'b0, v);
		chk_word("erased word", 32'hFFFF_FFFF, v);
		axi_wr(flash_pkg::OFS_DATA, 32'h0000_0000, rs);
		axi_wr(flash_pkg::OFS_CTRL, {16'h5A5A, 16'h0001}, rs);
		axi_rd(flash_pkg::OFS_CTRL, v, rs);
		chk_word("unkeyed control", 32'h0, v);
		flash_rd({wa[16:10], 10'h000}, 1'b0, v);
		chk_word("unkeyed word", 32'hFFFF_FFFF, v);
		axi_wr(flash_pkg::OFS_MASK, 32'h0000_0001, rs);
		axi_wr(flash_pkg::OFS_PE0, 32'hFFFF_FFFD, rs);
		axi_wr(flash_pkg::OFS_ADDR, 32'h0000_0800, rs);
		run_cmd(16'h0001, 1'b0);
		run_cmd(16'h0002, 1'b0);
		flash_rd(17'h00800, 1'b0, v);
		chk_word("protected word", 32'hFFFF_FFFF, v);
		axi_rd(flash_pkg::OFS_RAW, v, rs);
		chk_word("program violation", 32'h0000_0001, v);
		chk_flag("irq raised", 1'b1, irq);
		axi_wr(flash_pkg::OFS_CLR, 32'h0000_0003, rs);
		chk_flag("irq cleared", 1'b0, irq);
		axi_wr(flash_pkg::OFS_PE0, 32'hFFFF_FFFF, rs);
		axi_wr(flash_pkg::OFS_RE0, 32'hFFFF_FFFB, rs);
		d1 = $urandom;
		axi_wr(flash_pkg::OFS_DATA, d1, rs);
		axi_wr(flash_pkg::OFS_ADDR, 32'h0000_1000, rs);
		run_cmd(16'h0001, 1'b1);
		flash_rd(17'h01000, 1'b0, v);
		chk_word("read-protected data", 32'h0, v);
		flash_rd(17'h01000, 1'b1, v);
		chk_word("read-protected fetch", d1, v);
		axi_rd(flash_pkg::OFS_RAW, v, rs);
		chk_word("read violation", 32'h0000_0002, v);
		axi_wr(flash_pkg::OFS_RE0, 32'hFFFF_FFFF, rs);
		run_cmd(16'h0004, 1'b1);
		flash_rd(17'h01000, 1'b0, v);
		chk_word("mass erased word", 32'hFFFF_FFFF, v);
		axi_wr(flash_pkg::OFS_RE1, 32'hFFFF_FFFD, rs);
		axi_wr(flash_pkg::OFS_ADDR, {15'h0, flash_pkg::SEL_RE1}, rs);
		run_cmd(16'h0008, 1'b1);
		axi_wr(flash_pkg::OFS_PE1, 32'hFFFF_FFFE, rs);
		axi_wr(flash_pkg::OFS_RE0, 32'hFFFF_FFFE, rs);
		flash_rd(17'h00000, 1'b0, v);
		chk_word("uncommitted read block", 32'h0, v);
		do_reset(1'b1);
		axi_rd(flash_pkg::OFS_RE1, v, rs);
		chk_word("committed bit", 32'hFFFF_FFFD, v);
		axi_rd(flash_pkg::OFS_PE1, v, rs);
		chk_word("uncommitted bit", 32'hFFFF_FFFF, v);
		axi_rd(flash_pkg::OFS_RE0, v, rs);
		chk_word("uncommitted bit", 32'hFFFF_FFFF, v);
		do_reset(1'b0);
		axi_rd(flash_pkg::OFS_RE1, v, rs);
		chk_word("power-on image", 32'hFFFF_FFFF, v);
		give_verdict();
	end
endmodule
